// ==== hdl/csi_consts.svh ====
// Register offsets, field positions and reset values of the clock status and interrupt unit.
// Assumes the includer works at a single 100 MHz register clock.
`ifndef CSI_CONSTS_SVH
`define CSI_CONSTS_SVH

`define CSI_OFS_EN_LOCK_INPUTS 7'h68
`define CSI_OFS_EN_REF_HOLD 7'h69
`define CSI_OFS_STICKY_LOCK_INPUTS 7'h6c
`define CSI_OFS_LIVE_SELECT_LOCK 7'h6d
`define CSI_OFS_STICKY_REF_HOLD 7'h6e
`define CSI_OFS_LIVE_VCO_REF_HOLD 7'h6f

`define CSI_BIT_SYNTH 5
`define CSI_BIT_CLEANER 4
`define CSI_BIT_REF 1
`define CSI_BIT_HOLD 0

`define CSI_EN_LOCK_RESET 6'h00
`define CSI_EN_REF_HOLD_RESET 2'h0

`define CSI_FRAME_BITS 5'h10
`define CSI_CMD_BITS 5'h08
`define CSI_SYNC_STAGES 2

`endif

// ==== hdl/csi_pkg.sv ====
// Types shared by the clock status and interrupt unit.
// Assumes nothing beyond a SystemVerilog compiler.
package csi_pkg;

  typedef struct packed {
    logic [1:0] selected_input_code;
    logic synth_lock_loss_live_n;
    logic cleaner_lock_loss_live_n;
    logic [3:0] input_active_live;
    logic vco_status_live;
    logic ref_valid_live;
    logic holdover_live_n;
  } csi_live_status_t;

  typedef enum logic [1:0] {
    CSI_SPI_IDLE,
    CSI_SPI_CMD,
    CSI_SPI_WDATA,
    CSI_SPI_RDATA
  } csi_spi_state_t;

endpackage

// ==== hdl/csi_sticky_cell.sv ====
// One sticky event latch with write-one-to-clear.
// Assumes event and clear come from the same clock domain.
`timescale 1ns/1ps
`default_nettype none
module csi_sticky_cell
(
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic event_i,
  input wire logic clear_i,
  output logic seen_o
);

  // Set wins over clear so an event in the clearing cycle survives
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      seen_o <= 1'b0;
    else if (event_i)
      seen_o <= 1'b1;
    else if (clear_i)
      seen_o <= 1'b0;
  end

endmodule
`default_nettype wire

// ==== hdl/csi_status_irq.sv ====
// Status latches, interrupt enables and interrupt output, reached over a 3-wire serial port.
// Assumes serial pins and status monitors are asynchronous to ref_clk_i; all are synchronised.
`timescale 1ns/1ps
`default_nettype none
`include "csi_consts.svh"
module csi_status_irq
  import csi_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic spi_cs_n_i,
  input wire logic spi_sclk_i,
  input wire logic spi_sdio_i,
  output logic spi_sdio_o,
  output logic spi_sdio_oe_o,
  input wire csi_live_status_t live_status_i,
  output logic irq_out_n_o
);

  // Source order in the latch vector: inputs 0..3, cleaner, synth, holdover, reference
  localparam int NSRC = 8;
  localparam int SRC_CLEANER = 4;
  localparam int SRC_SYNTH = 5;
  localparam int SRC_HOLD = 6;
  localparam int SRC_REF = 7;

  // Two-flop synchronisers for pins and monitors
  logic [2:0] pin_meta;
  logic [2:0] pin_sync;
  logic [2:0] pin_last;
  csi_live_status_t live_meta;
  csi_live_status_t live;

  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      pin_meta <= 3'h1;
      pin_sync <= 3'h1;
      pin_last <= 3'h1;
    end
    else
    begin
      pin_meta <= {spi_sdio_i, spi_sclk_i, spi_cs_n_i};
      pin_sync <= pin_meta;
      pin_last <= pin_sync;
    end
  end

  // Monitors idle at "no fault" so reset does not fake an event
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      live_meta <= 11'h1ff;
      live <= 11'h1ff;
    end
    else
    begin
      live_meta <= live_status_i;
      live <= live_meta;
    end
  end

  logic cs_n;
  logic sclk_rise;
  logic sclk_fall;
  logic sdio_in;
  assign cs_n = pin_sync[0];
  assign sdio_in = pin_sync[2];
  assign sclk_rise = pin_sync[1] && !pin_last[1];
  assign sclk_fall = !pin_sync[1] && pin_last[1];

  // Serial frame: read flag, 7-bit address, 8 data bits, MSB first, sampled on sclk rise
  csi_spi_state_t state;
  logic [4:0] bit_cnt;
  logic [7:0] shift_in;
  logic [6:0] addr;
  logic [7:0] rd_shift;
  logic wr_pulse;
  logic [7:0] wr_data;
  logic [7:0] rd_data;

  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      state <= CSI_SPI_IDLE;
      bit_cnt <= 5'h00;
      shift_in <= 8'h00;
      addr <= 7'h00;
    end
    else if (cs_n)
    begin
      // Deselect aborts any partial frame; no write is committed
      state <= CSI_SPI_IDLE;
      bit_cnt <= 5'h00;
    end
    else if (sclk_rise)
    begin
      shift_in <= {shift_in[6:0], sdio_in};
      bit_cnt <= bit_cnt + 5'h01;
      case (state)
        CSI_SPI_IDLE, CSI_SPI_CMD:
        begin
          state <= CSI_SPI_CMD;
          if (bit_cnt == `CSI_CMD_BITS - 5'h01)
          begin
            addr <= {shift_in[5:0], sdio_in};
            state <= shift_in[6] ? CSI_SPI_RDATA : CSI_SPI_WDATA;
          end
        end
        CSI_SPI_WDATA, CSI_SPI_RDATA:
        begin
          if (bit_cnt == `CSI_FRAME_BITS - 5'h01)
            state <= CSI_SPI_IDLE;
        end
        default:
          state <= CSI_SPI_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      wr_pulse <= 1'b0;
      wr_data <= 8'h00;
    end
    else
    begin
      wr_pulse <= !cs_n && sclk_rise && state == CSI_SPI_WDATA && bit_cnt == `CSI_FRAME_BITS - 5'h01;
      wr_data <= {shift_in[6:0], sdio_in};
    end
  end

  // Read data goes out on sclk falls, so the host samples it on the next rise
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      rd_shift <= 8'h00;
      spi_sdio_o <= 1'b0;
      spi_sdio_oe_o <= 1'b0;
    end
    else if (cs_n || state != CSI_SPI_RDATA)
    begin
      rd_shift <= rd_data;
      spi_sdio_o <= 1'b0;
      spi_sdio_oe_o <= 1'b0;
    end
    else if (sclk_fall && bit_cnt == 5'h08)
    begin
      // Snapshot at the first fall, once this frame's address is known
      spi_sdio_o <= rd_data[7];
      spi_sdio_oe_o <= 1'b1;
      rd_shift <= {rd_data[6:0], 1'b0};
    end
    else if (sclk_fall)
    begin
      spi_sdio_o <= rd_shift[7];
      spi_sdio_oe_o <= 1'b1;
      rd_shift <= {rd_shift[6:0], 1'b0};
    end
  end

  // Enable registers keep implemented bits only, so reserved bits read 0
  logic [5:0] en_lock;
  logic [1:0] en_ref_hold;

  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      en_lock <= `CSI_EN_LOCK_RESET;
      en_ref_hold <= `CSI_EN_REF_HOLD_RESET;
    end
    else if (wr_pulse)
    begin
      if (addr == `CSI_OFS_EN_LOCK_INPUTS)
        en_lock <= wr_data[5:0];
      if (addr == `CSI_OFS_EN_REF_HOLD)
        en_ref_hold <= wr_data[1:0];
    end
  end

  // Events and write-one-to-clear strobes per source
  logic [NSRC-1:0] src_event;
  logic [NSRC-1:0] src_clear;
  logic [NSRC-1:0] seen;
  logic wr_sticky_lock;
  logic wr_sticky_ref;

  assign wr_sticky_lock = wr_pulse && addr == `CSI_OFS_STICKY_LOCK_INPUTS;
  assign wr_sticky_ref = wr_pulse && addr == `CSI_OFS_STICKY_REF_HOLD;
  assign src_event = {!live.ref_valid_live, !live.holdover_live_n, !live.synth_lock_loss_live_n,
                      !live.cleaner_lock_loss_live_n, ~live.input_active_live};
  assign src_clear = {{2{wr_sticky_ref}} & {wr_data[`CSI_BIT_REF], wr_data[`CSI_BIT_HOLD]},
                      {6{wr_sticky_lock}} & wr_data[5:0]};

  genvar g;
  generate
    for (g = 0; g < NSRC; g++)
    begin : gen_latch
      csi_sticky_cell u_cell
      (
        .ref_clk_i(ref_clk_i),
        .rst_b_i(rst_b_i),
        .event_i(src_event[g]),
        .clear_i(src_clear[g]),
        .seen_o(seen[g])
      );
    end
  endgenerate

  // Reference interrupt follows changes of its latch, not the level
  logic ref_seen_last;
  logic ref_pend;

  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      ref_seen_last <= 1'b0;
      ref_pend <= 1'b0;
    end
    else
    begin
      ref_seen_last <= seen[SRC_REF];
      if (seen[SRC_REF] != ref_seen_last)
        ref_pend <= 1'b1;
      else if (src_clear[SRC_REF])
        ref_pend <= 1'b0;
    end
  end

  logic next_irq;
  always_comb
  begin
    next_irq = |(seen[5:0] & en_lock);
    next_irq = next_irq | (seen[SRC_HOLD] & en_ref_hold[`CSI_BIT_HOLD]);
    next_irq = next_irq | (ref_pend & en_ref_hold[`CSI_BIT_REF]);
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      irq_out_n_o <= 1'b1;
    else
      irq_out_n_o <= !next_irq;
  end

  // Read mux: latches read 0 once an event was seen
  always_comb
  begin
    case (addr)
      `CSI_OFS_EN_LOCK_INPUTS: rd_data = {2'h0, en_lock};
      `CSI_OFS_EN_REF_HOLD: rd_data = {6'h00, en_ref_hold};
      `CSI_OFS_STICKY_LOCK_INPUTS: rd_data = {2'h0, ~seen[5:0]};
      `CSI_OFS_LIVE_SELECT_LOCK: rd_data = {live.selected_input_code, live.synth_lock_loss_live_n,
                                           live.cleaner_lock_loss_live_n, live.input_active_live};
      `CSI_OFS_STICKY_REF_HOLD: rd_data = {6'h00, ~seen[SRC_REF], ~seen[SRC_HOLD]};
      `CSI_OFS_LIVE_VCO_REF_HOLD: rd_data = {5'h00, live.vco_status_live, live.ref_valid_live,
                                            live.holdover_live_n};
      default: rd_data = 8'h00;
    endcase
  end

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_b_i);

  a_synth_irq_low: assert property (seen[SRC_SYNTH] && en_lock[`CSI_BIT_SYNTH] |=> !irq_out_n_o)
    else $error("synth lock loss did not pull interrupt low");
  a_cleaner_irq_low: assert property (seen[SRC_CLEANER] && en_lock[`CSI_BIT_CLEANER] |=> !irq_out_n_o)
    else $error("cleaner lock loss did not pull interrupt low");
  a_input_irq_low: assert property (|(seen[3:0] & en_lock[3:0]) |=> !irq_out_n_o)
    else $error("input loss did not pull interrupt low");
  a_ref_change_irq: assert property ($changed(seen[SRC_REF]) ##1 en_ref_hold[`CSI_BIT_REF]
    |=> !irq_out_n_o)
    else $error("reference change did not raise interrupt");
  a_hold_irq_low: assert property (seen[SRC_HOLD] && en_ref_hold[`CSI_BIT_HOLD] |=> !irq_out_n_o)
    else $error("holdover did not pull interrupt low");
  a_synth_event_kept: assert property (src_event[SRC_SYNTH] |=> seen[SRC_SYNTH] [*2] or
    (seen[SRC_SYNTH] ##1 $past(src_clear[SRC_SYNTH])))
    else $error("synth lock loss event not latched");
  a_synth_clear_drop: assert property (src_clear[SRC_SYNTH] && !src_event[SRC_SYNTH] |=> !seen[SRC_SYNTH])
    else $error("synth latch not cleared by write one");
  a_sticky_read_low: assert property (addr == `CSI_OFS_STICKY_LOCK_INPUTS |-> rd_data[5:0] == ~seen[5:0])
    else $error("sticky read value wrong");
  a_input_clear_drop: assert property (src_clear[0] && !src_event[0] |=> !seen[0])
    else $error("input latch not cleared");
  a_irq_release: assert property (!next_irq |=> irq_out_n_o)
    else $error("interrupt held without enabled cause");
  a_select_readout: assert property (addr == `CSI_OFS_LIVE_SELECT_LOCK |-> rd_data[7:6] == live.selected_input_code)
    else $error("selected input code misreported");
  a_reserved_zero: assert property (addr == `CSI_OFS_STICKY_REF_HOLD |-> rd_data[7:2] == 6'h00)
    else $error("reserved bits not zero");
  a_hold_clear_drop: assert property (src_clear[SRC_HOLD] && !src_event[SRC_HOLD] |=> !seen[SRC_HOLD])
    else $error("holdover latch not cleared");
  a_input_event_kept: assert property (src_event[0] |=> seen[0])
    else $error("input loss event not latched");

endmodule
`default_nettype wire

// ==== verif/csi_host_model.sv ====
// Host controller model for the three-wire serial configuration port.
// Assumes the bench resolves the shared data wire from both output enables.
`timescale 1ns/1ps
`default_nettype none
module csi_host_model
(
  input wire logic ref_clk_i,
  input wire logic sd_i,
  output logic cs_n_o,
  output logic sclk_o,
  output logic sd_o,
  output logic sd_oe_o
);
  // Serial clock phase in ref cycles; device needs at least 3
  int half = 5;
  initial
  begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    sd_o = 1'b0;
    sd_oe_o = 1'b0;
  end
  task automatic xfer(input logic rd, input logic [6:0] a, input logic [7:0] wd, output logic [7:0] rdat);
    logic [15:0] f;
    f = {rd, a, wd};
    rdat = 8'h00;
    @(negedge ref_clk_i);
    cs_n_o = 1'b0;
    sd_oe_o = 1'b1;
    for (int i = 15; i >= 0; i--)
    begin
      // Let go of the wire for the data half of a read
      if (rd && i < 8)
        sd_oe_o = 1'b0;
      sd_o = f[i];
      repeat (half) @(negedge ref_clk_i);
      if (i < 8)
        rdat[i] = sd_i;
      sclk_o = 1'b1;
      repeat (half) @(negedge ref_clk_i);
      sclk_o = 1'b0;
    end
    repeat (half) @(negedge ref_clk_i);
    cs_n_o = 1'b1;
    sd_oe_o = 1'b0;
    repeat (half) @(negedge ref_clk_i);
  endtask
endmodule
`default_nettype wire

// ==== verif/test_clock_status_interrupt_unit.sv ====
// Self-checking bench for the clock status and interrupt unit.
// Assumes csi_host_model on the serial port; live status driven at falling edges.
`timescale 1ns/1ps
`default_nettype none
`include "csi_consts.svh"
module test_clock_status_interrupt_unit import csi_pkg::*;;
  logic ref_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  csi_live_status_t live = '1;
  logic cs_n, sclk, h_d, h_oe, d_out, d_oe, irq_n, sdio;
  int mismatches = 0;
  int checks_done = 0;
  int seed = 32'h1061f9bf;
  logic [7:0] rv;
  always #5 ref_clk_i = ~ref_clk_i;
  // No pull on the wire, so an undriven wire shows the inverse of the last bit
  assign sdio = d_oe ? d_out : (h_oe ? h_d : ~h_d);
  csi_status_irq dut_u (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .spi_cs_n_i(cs_n), .spi_sclk_i(sclk),
    .spi_sdio_i(sdio), .spi_sdio_o(d_out), .spi_sdio_oe_o(d_oe), .live_status_i(live), .irq_out_n_o(irq_n));
  csi_host_model u_host (.ref_clk_i(ref_clk_i), .sd_i(sdio), .cs_n_o(cs_n), .sclk_o(sclk), .sd_o(h_d),
    .sd_oe_o(h_oe));
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    u_host.xfer(1'b0, a, d, rv);
  endtask
  task automatic rdc(input logic [6:0] a, input logic [7:0] exp);
    u_host.xfer(1'b1, a, 8'h00, rv);
    check($sformatf("reg %h", a), rv, exp);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  function automatic csi_live_status_t with_fault(csi_live_status_t s, int k);
    case (k)
      4: s.cleaner_lock_loss_live_n = 1'b0;
      5: s.synth_lock_loss_live_n = 1'b0;
      6: s.holdover_live_n = 1'b0;
      7: s.ref_valid_live = 1'b0;
      default: s.input_active_live[k] = 1'b0;
    endcase
    return s;
  endfunction
  function automatic logic [7:0] live_lock(csi_live_status_t s);
    return {s.selected_input_code, s.synth_lock_loss_live_n, s.cleaner_lock_loss_live_n, s.input_active_live};
  endfunction
  function automatic logic [7:0] live_ref(csi_live_status_t s);
    return {5'h00, s.vco_status_live, s.ref_valid_live, s.holdover_live_n};
  endfunction
  initial
  begin
    repeat (60000) @(posedge ref_clk_i);
    mismatches++;
    end_of_test();
  end
  initial
  begin
    csi_live_status_t base;
    logic [6:0] en_a, st_a;
    logic [7:0] idle, bitm, ev;
    logic en;
    int k;
    repeat (8) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    rst_b_i = 1'b1;
    repeat (5) @(negedge ref_clk_i);
    check("irq idle", {7'h00, irq_n}, 8'h01);
    rdc(`CSI_OFS_EN_LOCK_INPUTS, 8'h00);
    rdc(`CSI_OFS_EN_REF_HOLD, 8'h00);
    rdc(`CSI_OFS_STICKY_LOCK_INPUTS, 8'h3f);
    rdc(`CSI_OFS_STICKY_REF_HOLD, 8'h03);
    wr(`CSI_OFS_EN_LOCK_INPUTS, 8'hff);
    rdc(`CSI_OFS_EN_LOCK_INPUTS, 8'h3f);
    wr(`CSI_OFS_EN_REF_HOLD, 8'hff);
    rdc(`CSI_OFS_EN_REF_HOLD, 8'h03);
    wr(7'h6a, 8'hff);
    rdc(7'h6a, 8'h00);
    wr(`CSI_OFS_LIVE_SELECT_LOCK, 8'h00);
    rdc(`CSI_OFS_LIVE_SELECT_LOCK, live_lock(live));
    // First round enabled and fast, second disabled with a slow host
    for (int it = 0; it < 16; it++)
    begin
      k = it % 8;
      en = it < 8;
      u_host.half = en ? 5 : 9;
      base = '1;
      base.selected_input_code = 2'($random(seed));
      base.vco_status_live = 1'($random(seed));
      live = base;
      en_a = (k < 6) ? `CSI_OFS_EN_LOCK_INPUTS : `CSI_OFS_EN_REF_HOLD;
      st_a = (k < 6) ? `CSI_OFS_STICKY_LOCK_INPUTS : `CSI_OFS_STICKY_REF_HOLD;
      bitm = 8'h01 << ((k < 6) ? k : k - 6);
      idle = (k < 6) ? 8'h3f : 8'h03;
      ev = 8'($random(seed));
      wr(en_a, en ? (ev | bitm) : (ev & ~bitm));
      live = with_fault(base, k);
      repeat (10) @(negedge ref_clk_i);
      check("irq set", {7'h00, irq_n}, {7'h00, ~en});
      rdc(`CSI_OFS_LIVE_SELECT_LOCK, live_lock(live));
      rdc(`CSI_OFS_LIVE_VCO_REF_HOLD, live_ref(live));
      wr(st_a, bitm);
      rdc(st_a, idle & ~bitm);
      live = base;
      repeat (10) @(negedge ref_clk_i);
      rdc(st_a, idle & ~bitm);
      // A clear during the fault dropped the reference flag; the latch itself did not change
      check("irq held", {7'h00, irq_n}, {7'h00, ~(en && k != 7)});
      wr(st_a, bitm);
      check("irq relatch", {7'h00, irq_n}, {7'h00, ~(en && k == 7)});
      // Third clear drops a pending flag raised by the previous clear's change
      wr(st_a, bitm);
      rdc(st_a, idle);
      check("irq clear", {7'h00, irq_n}, 8'h01);
    end
    // Reset in mid-run with a pending cause: all returns to idle
    wr(`CSI_OFS_EN_LOCK_INPUTS, 8'h20);
    live = with_fault(base, 5);
    repeat (10) @(negedge ref_clk_i);
    check("irq before reset", {7'h00, irq_n}, 8'h00);
    rst_b_i = 1'b0;
    live = base;
    @(negedge ref_clk_i);
    check("irq in reset", {7'h00, irq_n}, 8'h01);
    rst_b_i = 1'b1;
    repeat (5) @(negedge ref_clk_i);
    rdc(`CSI_OFS_EN_LOCK_INPUTS, 8'h00);
    rdc(`CSI_OFS_STICKY_LOCK_INPUTS, 8'h3f);
    check("irq after reset", {7'h00, irq_n}, 8'h01);
    end_of_test();
  end
endmodule
`default_nettype wire
